// ===== src/flag_latch.sv
`default_nettype none
// Sticky out-of-limit flags with clear-on-read gated by the live condition
module flag_latch #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] fault,
    input  wire logic             read_clear,
    input  wire logic [WIDTH-1:0] seen,
    output logic      [WIDTH-1:0] flags
);
    import monitor_regs_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } latch_s;

    latch_s st;
    latch_s next_st;

    // Only flags seen as 1 clear; a fault present now re-sets them
    always_comb
    begin
        next_st = st;
        if (read_clear)
            next_st.flags = (st.flags & ~seen) | fault;
        else
            next_st.flags = st.flags | fault;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st.flags <= STATUS_ONE_RESET[WIDTH-1:0];
        else
            st <= next_st;
    end

    assign flags = st.flags;
endmodule : flag_latch
`default_nettype wire

// ===== src/monitor_config_and_status1.sv
`default_nettype none
// Functional notes
// - Run bit set: monitor and drive PWM from programmed limits.
// - Run bit clear: stop monitoring, PWM from default power-up limits.
// - Clearing run bit leaves programmed limits untouched.
// - Run bit stays writable after lock.
// - Monitoring stopped forces every PWM to full duty.
// - Lock bit is write-once; locks lockable registers until power cycle.
// - Writes to locked fields are ignored, contents kept.
// - Ready flag reads 1 once powered up and able to monitor.
// - Boost bit forces full duty; clearing returns to automatic speed.
// - Boost bit stays writable after lock.
// - Bit 4 enables CPU thermal polling; read-only once locked.
// - Bit 5: overtemp or failsafe drives full duty even in manual; locks.
// - Status register one resets to zero.
// - Bits 0-3 latch on voltage out-of-limit.
// - Read clears a latched flag only when its fault has gone.
// - With overtemp pin mode, bit 0 sets on timer limit exceeded.
// - Bits 4-6 latch on remote one, local, remote two temperature faults.
// - Bit 7 is OR of status register two.
module monitor_config_and_status1
    import monitor_regs_pkg::*;
#(
    parameter int NUM_PWM = 3,
    parameter int READY_DELAY = POWER_UP_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register access
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Fault sources
    input  wire logic [3:0]           voltage_fault,
    input  wire logic                 overtemp_pin_mode,
    input  wire logic                 overtemp_timer_exceeded,
    input  wire logic [2:0]           temp_fault,
    input  wire logic [7:0]           status_two,
    input  wire logic                 overtemp_signal,
    input  wire logic                 cpu_failsafe_limit,
    // Fan control
    input  wire logic [NUM_PWM*8-1:0] auto_duty,
    input  wire logic [NUM_PWM-1:0]   manual_mode,
    output logic      [NUM_PWM*8-1:0] pwm_duty,
    // Configuration state
    output logic                      monitoring_run,
    output logic                      use_programmed_limits,
    output logic                      limits_locked,
    output logic                      cpu_thermal_poll_enable
);
    typedef struct packed {
        logic                 run;
        logic                 lock;
        logic                 ready;
        logic                 boost;
        logic                 poll;
        logic                 override_manual;
        logic [15:0]          ready_count;
        logic [7:0]           rdata;
        logic [NUM_PWM*8-1:0] duty;
    } state_s;

    state_s st;
    state_s next_st;
    logic [7:0] status_flags;
    logic [7:0] status_view;
    logic [7:0] fault_vec;
    logic       status_read;
    logic       force_full;
    logic       alarm;

    localparam logic [15:0] READY_LAST = 16'(READY_DELAY);

    function automatic logic [7:0] cfg_image(input state_s s);
        logic [7:0] v;
        v = 8'h00;
        v[RUN_BIT]      = s.run;
        v[LOCK_BIT]     = s.lock;
        v[READY_BIT]    = s.ready;
        v[BOOST_BIT]    = s.boost;
        v[POLL_BIT]     = s.poll;
        v[OVERRIDE_BIT] = s.override_manual;
        return v;
    endfunction : cfg_image

    // Full duty wins over all; an alarm reaches a manual fan only through the override bit
    function automatic logic [7:0] pick_duty(
        input logic       force_all,
        input logic       alarm_now,
        input logic       manual,
        input logic       reach_manual,
        input logic [7:0] auto_value
    );
        logic [7:0] d;
        d = auto_value;
        if (alarm_now && (reach_manual || !manual))
            d = FULL_DUTY;
        if (force_all)
            d = FULL_DUTY;
        return d;
    endfunction : pick_duty

    // Pin mode steers the bit-0 source between voltage and overtemp timer
    always_comb
    begin
        fault_vec = {1'b0, temp_fault, voltage_fault};
        if (overtemp_pin_mode)
            fault_vec[0] = overtemp_timer_exceeded;
    end

    assign status_read = reg_rd && (reg_addr == STATUS_ONE_ADDR);
    assign status_view = {|status_two, status_flags[6:0]};

    flag_latch #(
        .WIDTH (8)
    ) flag_latch_inst (
        .clk        (clk),
        .rst_n      (rst_n),
        .fault      (fault_vec),
        .read_clear (status_read),
        .seen       (status_flags),
        .flags      (status_flags)
    );

    always_comb
    begin
        next_st = st;

        // Ready is set at power-on; the count only matters if it is ever cleared
        if (!st.ready)
        begin
            if (st.ready_count >= READY_LAST)
                next_st.ready = 1'b1;
            else
                next_st.ready_count = st.ready_count + 16'h0001;
        end

        // Run and boost stay writable under lock; the lockable bits do not
        if (reg_wr && reg_addr == CFG_ONE_ADDR)
        begin
            next_st.run   = reg_wdata[RUN_BIT];
            next_st.boost = reg_wdata[BOOST_BIT];
            if (!st.lock)
            begin
                next_st.lock            = reg_wdata[LOCK_BIT];
                next_st.poll            = reg_wdata[POLL_BIT];
                next_st.override_manual = reg_wdata[OVERRIDE_BIT];
            end
        end

        // Read data stands for one cycle, then falls back to zero
        next_st.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                CFG_ONE_ADDR:    next_st.rdata = cfg_image(st);
                STATUS_ONE_ADDR: next_st.rdata = status_view;
                default:         next_st.rdata = 8'h00;
            endcase
        end

        // Alarm is judged per fan, so a manual fan keeps its setting unless overridden
        alarm      = overtemp_signal || cpu_failsafe_limit;
        force_full = !st.run || st.boost;
        for (int i = 0; i < NUM_PWM; i++)
        begin
            next_st.duty[i*8 +: 8] = pick_duty(force_full, alarm, manual_mode[i], st.override_manual,
                                               auto_duty[i*8 +: 8]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.ready <= CFG_ONE_RESET[READY_BIT];
            st.ready_count <= 16'h0000;
            st.duty <= {NUM_PWM{FULL_DUTY}};
        end
        else
            st <= next_st;
    end

    assign reg_rdata               = st.rdata;
    assign pwm_duty                = st.duty;
    assign monitoring_run          = st.run;
    assign use_programmed_limits   = st.run;
    assign limits_locked           = st.lock;
    assign cpu_thermal_poll_enable = st.poll;

    // Named steps of a register access, plus the fans-on-auto condition, for the checks below
    sequence s_cfg_write;
        reg_wr && reg_addr == CFG_ONE_ADDR;
    endsequence

    sequence s_open_cfg_write;
        reg_wr && reg_addr == CFG_ONE_ADDR && !st.lock;
    endsequence

    sequence s_cfg_read;
        reg_rd && reg_addr == CFG_ONE_ADDR;
    endsequence

    sequence s_status_read;
        reg_rd && reg_addr == STATUS_ONE_ADDR;
    endsequence

    sequence s_fans_on_auto;
        st.run && !st.boost && !overtemp_signal && !cpu_failsafe_limit;
    endsequence

    a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        st.lock |=> st.lock)
        else $error("lock cleared");
    a_lock_poll: assert property (@(posedge clk) disable iff (!rst_n)
        st.lock |=> $stable(st.poll))
        else $error("poll changed while locked");
    a_lock_ovr: assert property (@(posedge clk) disable iff (!rst_n)
        st.lock |=> $stable(st.override_manual))
        else $error("override changed while locked");
    a_run_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == CFG_ONE_ADDR |=> st.run == $past(reg_wdata[RUN_BIT]))
        else $error("run write lost");
    a_boost_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == CFG_ONE_ADDR |=> st.boost == $past(reg_wdata[BOOST_BIT]))
        else $error("boost write lost");
    a_stop_full: assert property (@(posedge clk) disable iff (!rst_n)
        !st.run |=> pwm_duty == {NUM_PWM{FULL_DUTY}})
        else $error("stopped but not full duty");
    a_boost_full: assert property (@(posedge clk) disable iff (!rst_n)
        st.boost |=> pwm_duty == {NUM_PWM{FULL_DUTY}})
        else $error("boost but not full duty");
    a_fault_latch: assert property (@(posedge clk) disable iff (!rst_n)
        fault_vec[6:0] != 7'h00 |=> (status_flags[6:0] & $past(fault_vec[6:0])) == $past(fault_vec[6:0]))
        else $error("fault not latched");
    a_summary_or: assert property (@(posedge clk) disable iff (!rst_n)
        status_read |=> reg_rdata[SUMMARY_BIT] == $past(|status_two))
        else $error("summary bit wrong");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == CFG_ONE_ADDR |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved bits nonzero");

    // Reset, register and fan checks
    a_reset_flags: assert property (@(posedge clk)
        !rst_n |=> status_flags == STATUS_ONE_RESET)
        else $error("status not cleared by reset");

    a_reset_config: assert property (@(posedge clk)
        !rst_n |=> !st.run && !st.lock && !st.boost && st.ready && pwm_duty == {NUM_PWM{FULL_DUTY}})
        else $error("config defaults wrong after reset");

    a_ready_kept: assert property (@(posedge clk) disable iff (!rst_n)
        st.ready |=> st.ready)
        else $error("ready flag dropped");

    a_lock_set: assert property (@(posedge clk) disable iff (!rst_n)
        (s_open_cfg_write ##0 reg_wdata[LOCK_BIT]) |=> st.lock)
        else $error("lock write lost");

    a_poll_write: assert property (@(posedge clk) disable iff (!rst_n)
        s_open_cfg_write |=> st.poll == $past(reg_wdata[POLL_BIT]))
        else $error("poll write lost while unlocked");

    a_ovr_write: assert property (@(posedge clk) disable iff (!rst_n)
        s_open_cfg_write |=> st.override_manual == $past(reg_wdata[OVERRIDE_BIT]))
        else $error("override write lost while unlocked");

    a_cfg_readback: assert property (@(posedge clk) disable iff (!rst_n)
        s_cfg_read |=> reg_rdata == $past({2'b00, st.override_manual, st.poll, st.boost, st.ready, st.lock, st.run}))
        else $error("config readback wrong");

    a_auto_duty: assert property (@(posedge clk) disable iff (!rst_n)
        s_fans_on_auto |=> pwm_duty == $past(auto_duty))
        else $error("automatic duty not passed through");

    a_override_full: assert property (@(posedge clk) disable iff (!rst_n)
        (overtemp_signal || cpu_failsafe_limit) && st.override_manual |=> pwm_duty == {NUM_PWM{FULL_DUTY}})
        else $error("alarm with override but not full duty");

    a_manual_fan0: assert property (@(posedge clk) disable iff (!rst_n)
        st.run && !st.boost && overtemp_signal && !st.override_manual && manual_mode[0]
        |=> pwm_duty[7:0] == $past(auto_duty[7:0]))
        else $error("manual fan forced without override");

    a_read_snapshot: assert property (@(posedge clk) disable iff (!rst_n)
        s_status_read |=> reg_rdata[6:0] == $past(status_flags[6:0]))
        else $error("status read data wrong");

    a_clear_on_read: assert property (@(posedge clk) disable iff (!rst_n)
        s_status_read |=> status_flags[6:0] == $past(fault_vec[6:0]))
        else $error("clear on read wrong");

    a_flags_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        !status_read |=> (status_flags & $past(status_flags)) == $past(status_flags))
        else $error("flag dropped without read");

    a_pin_mode_bit0: assert property (@(posedge clk) disable iff (!rst_n)
        overtemp_pin_mode && overtemp_timer_exceeded |=> status_flags[0])
        else $error("timer limit not latched");
endmodule : monitor_config_and_status1
`default_nettype wire

// ===== src/monitor_regs_pkg.sv
`default_nettype none
package monitor_regs_pkg;
    localparam logic [7:0] CFG_ONE_ADDR    = 8'h40;
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h41;
    localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
    localparam int RUN_BIT      = 0;
    localparam int LOCK_BIT     = 1;
    localparam int READY_BIT    = 2;
    localparam int BOOST_BIT    = 3;
    localparam int POLL_BIT     = 4;
    localparam int OVERRIDE_BIT = 5;
    localparam int SUMMARY_BIT  = 7;
    localparam logic [7:0] CFG_ONE_RESET    = 8'h04;
    localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
    localparam logic [7:0] FULL_DUTY        = 8'hff;
    localparam int POWER_UP_NS     = 1000;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int POWER_UP_CYCLES = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : monitor_regs_pkg
`default_nettype wire

// ===== verif/monitor_config_and_status1_tb.sv
`default_nettype none
module monitor_config_and_status1_tb import monitor_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and bus
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    // Fault sources and fans
    logic [3:0]  voltage_fault = 4'h0;
    logic        overtemp_pin_mode = 1'b0;
    logic        overtemp_timer_exceeded = 1'b0;
    logic [2:0]  temp_fault = 3'h0;
    logic [7:0]  status_two = 8'h00;
    logic        overtemp_signal = 1'b0;
    logic        cpu_failsafe_limit = 1'b0;
    logic [23:0] auto_duty = 24'h302010;
    logic [2:0]  manual_mode = 3'h0;
    logic [23:0] pwm_duty;
    logic        monitoring_run;
    logic        use_programmed_limits;
    logic        limits_locked;
    logic        cpu_thermal_poll_enable;
    int          errors = 0;
    int          checked = 0;

    monitor_config_and_status1 #(.NUM_PWM(3)) monitor_config_and_status1_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .voltage_fault(voltage_fault),
        .overtemp_pin_mode(overtemp_pin_mode), .overtemp_timer_exceeded(overtemp_timer_exceeded),
        .temp_fault(temp_fault), .status_two(status_two), .overtemp_signal(overtemp_signal),
        .cpu_failsafe_limit(cpu_failsafe_limit), .auto_duty(auto_duty), .manual_mode(manual_mode),
        .pwm_duty(pwm_duty), .monitoring_run(monitoring_run), .use_programmed_limits(use_programmed_limits),
        .limits_locked(limits_locked), .cpu_thermal_poll_enable(cpu_thermal_poll_enable));

    always #4 clk = ~clk;

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Write lands at the strobe edge; duty follows one edge later, so wait both
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk(name, {16'h0, reg_rdata}, {16'h0, exp});
    endtask : rdc

    task automatic t_reset();
        chk("duty", pwm_duty, 24'hffffff);
        chk("run", {23'h0, use_programmed_limits}, 24'h0);
        rdc(CFG_ONE_ADDR, 8'h04, "cfg");
        rdc(STATUS_ONE_ADDR, 8'h00, "status");
        $display("test reset done");
    endtask : t_reset

    task automatic t_run();
        wr(CFG_ONE_ADDR, 8'hc1);
        chk("limits", {23'h0, use_programmed_limits}, 24'h1);
        chk("duty", pwm_duty, auto_duty);
        rdc(CFG_ONE_ADDR, 8'h05, "cfg");
        wr(CFG_ONE_ADDR, 8'h09);
        chk("duty", pwm_duty, 24'hffffff);
        wr(CFG_ONE_ADDR, 8'h01);
        chk("duty", pwm_duty, auto_duty);
        $display("test run done");
    endtask : t_run

    task automatic t_override();
        manual_mode = 3'b101;
        overtemp_signal = 1'b1;
        tick(1);
        chk("duty", pwm_duty, 24'h30ff10);
        wr(CFG_ONE_ADDR, 8'h21);
        chk("duty", pwm_duty, 24'hffffff);
        overtemp_signal = 1'b0;
        cpu_failsafe_limit = 1'b1;
        tick(1);
        chk("duty", pwm_duty, 24'hffffff);
        cpu_failsafe_limit = 1'b0;
        manual_mode = 3'b000;
        tick(1);
        chk("duty", pwm_duty, auto_duty);
        $display("test override done");
    endtask : t_override

    task automatic t_flags();
        voltage_fault = 4'h5;
        temp_fault = 3'b010;
        status_two = 8'h10;
        tick(1);
        voltage_fault = 4'h4;
        temp_fault = 3'b000;
        rdc(STATUS_ONE_ADDR, 8'ha5, "status");
        rdc(STATUS_ONE_ADDR, 8'h84, "status");
        voltage_fault = 4'h0;
        status_two = 8'h00;
        rdc(STATUS_ONE_ADDR, 8'h04, "status");
        rdc(STATUS_ONE_ADDR, 8'h00, "status");
        overtemp_pin_mode = 1'b1;
        overtemp_timer_exceeded = 1'b1;
        tick(1);
        overtemp_timer_exceeded = 1'b0;
        rdc(STATUS_ONE_ADDR, 8'h01, "status");
        $display("test flags done");
    endtask : t_flags

    task automatic t_lock();
        wr(CFG_ONE_ADDR, 8'h33);
        chk("lock", {22'h0, limits_locked, cpu_thermal_poll_enable}, 24'h3);
        wr(CFG_ONE_ADDR, 8'h08);
        chk("run", {22'h0, monitoring_run, use_programmed_limits}, 24'h0);
        rdc(CFG_ONE_ADDR, 8'h3e, "cfg");
        wr(CFG_ONE_ADDR, 8'h00);
        rdc(CFG_ONE_ADDR, 8'h36, "cfg");
        chk("duty", pwm_duty, 24'hffffff);
        $display("test lock done");
    endtask : t_lock

    task automatic t_power_cycle();
        rst_n = 1'b0;
        tick(8);
        rst_n = 1'b1;
        chk("lock", {22'h0, limits_locked, cpu_thermal_poll_enable}, 24'h0);
        chk("duty", pwm_duty, 24'hffffff);
        rdc(CFG_ONE_ADDR, 8'h04, "cfg");
        wr(CFG_ONE_ADDR, 8'h03);
        wr(CFG_ONE_ADDR, 8'h10);
        chk("lock", {22'h0, limits_locked, cpu_thermal_poll_enable}, 24'h2);
        rdc(STATUS_ONE_ADDR, 8'h00, "status");
        $display("test power cycle done");
    endtask : t_power_cycle

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial
    begin
        tick(8);
        rst_n = 1'b1;
        t_reset();
        t_run();
        t_override();
        t_flags();
        t_lock();
        t_power_cycle();
        conclude();
    end
endmodule : monitor_config_and_status1_tb
`default_nettype wire
